/* hfc_pkg.sv */
// Shared constants and types for the holdover frequency control registers
package hfc_pkg;

  // ==========================================================
  // Register offsets on the microprocessor port
  localparam logic [6:0] HFC_ADDR_OFFSET_LOW = 7'h3E;
  localparam logic [6:0] HFC_ADDR_OFFSET_MID = 7'h3F;
  localparam logic [6:0] HFC_ADDR_POLICY     = 7'h40;

  // ==========================================================
  // Reset values
  localparam logic [7:0] HFC_RST_OFFSET_LOW = 8'h00;
  localparam logic [7:0] HFC_RST_OFFSET_MID = 8'h00;
  localparam logic [7:0] HFC_RST_POLICY     = 8'h88;
  localparam logic [7:0] HFC_READ_UNMAPPED  = 8'h00;

  // ==========================================================
  // Policy register field positions
  localparam int HFC_BIT_AUTO_AVG  = 7;
  localparam int HFC_BIT_FAST_AVG  = 6;
  localparam int HFC_BIT_READ_AVG  = 5;
  localparam int HFC_BRIEF_MSB     = 4;
  localparam int HFC_BRIEF_LSB     = 3;
  localparam int HFC_OFFS_HI_MSB   = 2;
  localparam int HFC_OFFS_HI_LSB   = 0;
  localparam int HFC_OFFSET_WIDTH  = 19;

  // ==========================================================
  // Brief-hold policy codes
  localparam logic [1:0] HFC_BRIEF_FULL   = 2'h0;
  localparam logic [1:0] HFC_BRIEF_FROZEN = 2'h1;
  localparam logic [1:0] HFC_BRIEF_FAST   = 2'h2;
  localparam logic [1:0] HFC_BRIEF_SLOW   = 2'h3;

  // ==========================================================
  // Frequency source used by the timing loop, one-hot
  typedef enum logic [3:0] {
    HFC_SRC_MANUAL = 4'h1,
    HFC_SRC_FROZEN = 4'h2,
    HFC_SRC_FAST   = 4'h4,
    HFC_SRC_SLOW   = 4'h8
  } hfc_src_t;

endpackage

/* hfc_rd_if.sv */
// Read-back path between register bank and read data mux
`timescale 1ns/1ps
interface hfc_rd_if;
  logic        rd_strobe;
  logic [6:0]  addr;
  logic [18:0] prog_word;
  logic        read_avg;
  logic        fast_sel;
  logic [4:3]  policy_upper;
  logic        auto_avg;
  logic [7:0]  rdata;

  modport bank (output rd_strobe, output addr, output prog_word, output read_avg,
                output fast_sel, output policy_upper, output auto_avg, input rdata);
  modport mux  (input rd_strobe, input addr, input prog_word, input read_avg,
                input fast_sel, input policy_upper, input auto_avg, output rdata);
endinterface

/* hfc_readback.sv */
// Registered read data mux for the holdover registers
`timescale 1ns/1ps
module hfc_readback (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic [18:0] fast_avg,
  input  wire logic [18:0] slow_avg,
  hfc_rd_if.mux            rd
);

  logic [18:0] avg_word;
  logic [18:0] shown_word;

  // ==========================================================
  // Word shown on offset reads
  assign avg_word   = rd.fast_sel ? fast_avg : slow_avg;
  assign shown_word = rd.read_avg ? avg_word : rd.prog_word;

  // Read data register, updated on each read strobe
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rd.rdata <= hfc_pkg::HFC_READ_UNMAPPED;
    end else if (rd.rd_strobe) begin
      unique case (rd.addr)
        hfc_pkg::HFC_ADDR_OFFSET_LOW: rd.rdata <= shown_word[7:0];
        hfc_pkg::HFC_ADDR_OFFSET_MID: rd.rdata <= shown_word[15:8];
        hfc_pkg::HFC_ADDR_POLICY:     rd.rdata <= {rd.auto_avg, rd.fast_sel, rd.read_avg,
                                                   rd.policy_upper,
                                                   shown_word[18:16]};
        default:                      rd.rdata <= hfc_pkg::HFC_READ_UNMAPPED;
      endcase
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  property p_read_prog;
    rd.rd_strobe && !rd.read_avg && rd.addr == hfc_pkg::HFC_ADDR_OFFSET_LOW
      |=> rd.rdata == $past(rd.prog_word[7:0]);
  endproperty
  a_read_prog: assert property (p_read_prog) else $error("low byte readback wrong");

  property p_read_fast;
    rd.rd_strobe && rd.read_avg && rd.fast_sel && rd.addr == hfc_pkg::HFC_ADDR_OFFSET_MID
      |=> rd.rdata == $past(fast_avg[15:8]);
  endproperty
  a_read_fast: assert property (p_read_fast) else $error("fast average readback wrong");

  property p_read_slow;
    rd.rd_strobe && rd.read_avg && !rd.fast_sel && rd.addr == hfc_pkg::HFC_ADDR_OFFSET_LOW
      |=> rd.rdata == $past(slow_avg[7:0]);
  endproperty
  a_read_slow: assert property (p_read_slow) else $error("slow average readback wrong");

endmodule

/* hfc_regs.sv */
// Holdover frequency control register bank, top level
`timescale 1ns/1ps
// Behaviour
// - Low offset byte is read/write, holds offset bits 7:0, resets to zero.
// - Offset word is policy bits 2:0, middle byte, low byte concatenated.
// - The 19-bit offset word is signed two's complement versus the crystal.
// - Policy bit 5 makes offset reads return the averaged frequency.
// - Policy register resets to 0x88 with fields in bits 7,6,5,4:3,2:0.
// - Bit 7 picks averaged over frozen; manual holdover takes precedence for full holdover and brief code 00 only.
// - Policy bit 6 selects fast (1) or slow (0) averaging rate.
// - Read-back 0 returns written value; 1 returns fast or slow average.
// - Brief-hold code: 00 full, 01 frozen, 10 fast, 11 slow.
module hfc_regs (
  input  wire logic                        clock,
  input  wire logic                        resetn,
  input  wire logic                        cs,
  input  wire logic                        wr_strobe,
  input  wire logic                        rd_strobe,
  input  wire logic [6:0]                  addr,
  input  wire logic [7:0]                  wdata,
  input  wire logic                        manual_holdover_sel,
  input  wire logic [18:0]                 fast_avg,
  input  wire logic [18:0]                 slow_avg,
  output logic      [7:0]                  rdata,
  output logic signed [18:0]               hold_offset_word,
  output logic                             fast_avg_select,
  output hfc_pkg::hfc_src_t                hold_source,
  output hfc_pkg::hfc_src_t                brief_source
);

  logic [7:0] hold_offset_low;
  logic [7:0] hold_offset_mid;
  logic [7:0] hold_policy_control;
  logic       wr_low;
  logic       wr_mid;
  logic       wr_pol;
  hfc_pkg::hfc_src_t next_hold_source;
  hfc_pkg::hfc_src_t next_brief_source;
  hfc_pkg::hfc_src_t avg_src;

  hfc_rd_if rd ();

  // ==========================================================
  // Write decode
  assign wr_low = cs && wr_strobe && addr == hfc_pkg::HFC_ADDR_OFFSET_LOW;
  assign wr_mid = cs && wr_strobe && addr == hfc_pkg::HFC_ADDR_OFFSET_MID;
  assign wr_pol = cs && wr_strobe && addr == hfc_pkg::HFC_ADDR_POLICY;

  // Low offset byte
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hold_offset_low <= hfc_pkg::HFC_RST_OFFSET_LOW;
    end else if (wr_low) begin
      hold_offset_low <= wdata;
    end
  end

  // Middle offset byte
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hold_offset_mid <= hfc_pkg::HFC_RST_OFFSET_MID;
    end else if (wr_mid) begin
      hold_offset_mid <= wdata;
    end
  end

  // Policy register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hold_policy_control <= hfc_pkg::HFC_RST_POLICY;
    end else if (wr_pol) begin
      hold_policy_control <= wdata;
    end
  end

  // ==========================================================
  // Offset word out, signed, no conversion of written format
  // The word is not updated atomically: each byte write lands on its own,
  // so the timing loop may see a mixed word between writes. Software should
  // finish all three byte writes before relying on the word.
  assign hold_offset_word = {hold_policy_control[hfc_pkg::HFC_OFFS_HI_MSB:hfc_pkg::HFC_OFFS_HI_LSB],
                             hold_offset_mid, hold_offset_low};
  assign fast_avg_select  = hold_policy_control[hfc_pkg::HFC_BIT_FAST_AVG];

  // ==========================================================
  // Source selection for full and brief holdover
  always_comb begin
    avg_src = fast_avg_select ? hfc_pkg::HFC_SRC_FAST : hfc_pkg::HFC_SRC_SLOW;
    if (manual_holdover_sel) begin
      next_hold_source = hfc_pkg::HFC_SRC_MANUAL;
    end else if (hold_policy_control[hfc_pkg::HFC_BIT_AUTO_AVG]) begin
      next_hold_source = avg_src;
    end else begin
      next_hold_source = hfc_pkg::HFC_SRC_FROZEN;
    end
    unique case (hold_policy_control[hfc_pkg::HFC_BRIEF_MSB:hfc_pkg::HFC_BRIEF_LSB])
      hfc_pkg::HFC_BRIEF_FULL:   next_brief_source = next_hold_source;
      hfc_pkg::HFC_BRIEF_FROZEN: next_brief_source = hfc_pkg::HFC_SRC_FROZEN;
      hfc_pkg::HFC_BRIEF_FAST:   next_brief_source = hfc_pkg::HFC_SRC_FAST;
      hfc_pkg::HFC_BRIEF_SLOW:   next_brief_source = hfc_pkg::HFC_SRC_SLOW;
    endcase
  end

  // Registered source outputs
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hold_source  <= hfc_pkg::HFC_SRC_FAST;
      brief_source <= hfc_pkg::HFC_SRC_FAST;
    end else begin
      hold_source  <= next_hold_source;
      brief_source <= next_brief_source;
    end
  end

  // ==========================================================
  // Read path
  assign rd.rd_strobe    = cs && rd_strobe;
  assign rd.addr         = addr;
  assign rd.prog_word    = hold_offset_word;
  assign rd.read_avg     = hold_policy_control[hfc_pkg::HFC_BIT_READ_AVG];
  assign rd.fast_sel     = fast_avg_select;
  assign rd.policy_upper = hold_policy_control[hfc_pkg::HFC_BRIEF_MSB:hfc_pkg::HFC_BRIEF_LSB];
  assign rd.auto_avg     = hold_policy_control[hfc_pkg::HFC_BIT_AUTO_AVG];
  assign rdata           = rd.rdata;

  hfc_readback u_readback (
    .clock    (clock),
    .resetn   (resetn),
    .fast_avg (fast_avg),
    .slow_avg (slow_avg),
    .rd       (rd.mux)
  );

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  property p_low_write;
    wr_low |=> hold_offset_word[7:0] == $past(wdata);
  endproperty
  a_low_write: assert property (p_low_write) else $error("low byte not written");

  property p_mid_write;
    wr_mid |=> hold_offset_word[15:8] == $past(wdata);
  endproperty
  a_mid_write: assert property (p_mid_write) else $error("middle byte not written");

  property p_offset_msb;
    wr_pol |=> hold_offset_word[18:16] == $past(wdata[2:0]);
  endproperty
  a_offset_msb: assert property (p_offset_msb) else $error("offset top bits wrong");

  property p_offset_hold;
    !wr_low && !wr_mid && !wr_pol |=> hold_offset_word == $past(hold_offset_word);
  endproperty
  a_offset_hold: assert property (p_offset_hold) else $error("offset word drifted");

  property p_sign;
    hold_policy_control[2] |-> hold_offset_word < 0;
  endproperty
  a_sign: assert property (p_sign) else $error("offset sign wrong");

  property p_policy_write;
    wr_pol |=> hold_policy_control == $past(wdata) && fast_avg_select == $past(wdata[6]);
  endproperty
  a_policy_write: assert property (p_policy_write) else $error("policy not written");

  property p_policy_hold;
    !wr_pol |=> hold_policy_control == $past(hold_policy_control);
  endproperty
  a_policy_hold: assert property (p_policy_hold) else $error("policy changed unwritten");

  property p_manual;
    manual_holdover_sel |=> hold_source == hfc_pkg::HFC_SRC_MANUAL;
  endproperty
  a_manual: assert property (p_manual) else $error("manual not preferred");

  property p_frozen;
    !manual_holdover_sel && !hold_policy_control[7] |=> hold_source == hfc_pkg::HFC_SRC_FROZEN;
  endproperty
  a_frozen: assert property (p_frozen) else $error("frozen not chosen");

  property p_rate;
    !manual_holdover_sel && hold_policy_control[7] && !hold_policy_control[6]
      |=> hold_source == hfc_pkg::HFC_SRC_SLOW;
  endproperty
  a_rate: assert property (p_rate) else $error("averaging rate wrong");

  property p_rate_fast;
    !manual_holdover_sel && hold_policy_control[7] && hold_policy_control[6]
      |=> hold_source == hfc_pkg::HFC_SRC_FAST;
  endproperty
  a_rate_fast: assert property (p_rate_fast) else $error("fast averaging not chosen");

  property p_brief;
    hold_policy_control[4:3] == hfc_pkg::HFC_BRIEF_FROZEN
      |=> brief_source == hfc_pkg::HFC_SRC_FROZEN;
  endproperty
  a_brief: assert property (p_brief) else $error("brief hold source wrong");

  property p_brief_fast;
    hold_policy_control[4:3] == hfc_pkg::HFC_BRIEF_FAST
      |=> brief_source == hfc_pkg::HFC_SRC_FAST;
  endproperty
  a_brief_fast: assert property (p_brief_fast) else $error("brief fast source wrong");

  property p_brief_slow;
    hold_policy_control[4:3] == hfc_pkg::HFC_BRIEF_SLOW
      |=> brief_source == hfc_pkg::HFC_SRC_SLOW;
  endproperty
  a_brief_slow: assert property (p_brief_slow) else $error("brief slow source wrong");

  property p_brief_full;
    hold_policy_control[4:3] == hfc_pkg::HFC_BRIEF_FULL |=> brief_source == hold_source;
  endproperty
  a_brief_full: assert property (p_brief_full) else $error("brief full mismatch");

  c_manual:   cover property (manual_holdover_sel ##1 hold_source == hfc_pkg::HFC_SRC_MANUAL);
  c_avg_read: cover property (rd.rd_strobe && rd.read_avg);
  c_brief:    cover property (brief_source == hfc_pkg::HFC_SRC_SLOW);
  c_frozen:   cover property (hold_source == hfc_pkg::HFC_SRC_FROZEN);
  c_wr_pair:  cover property (wr_mid ##2 wr_pol);

endmodule

/* hfc_regs_tb.sv */
// Self-checking testbench for the holdover frequency control registers
`timescale 1ns/1ps
module hfc_regs_tb;
  // ==========================================================
  // Stimulus and observed signals
  logic                    clock;
  logic                    resetn;
  logic                    cs;
  logic                    wr_strobe;
  logic                    rd_strobe;
  logic [6:0]              addr;
  logic [7:0]              wdata;
  logic                    manual_holdover_sel;
  logic [18:0]             fast_avg;
  logic [18:0]             slow_avg;
  logic [7:0]              rdata;
  logic signed [18:0]      hold_offset_word;
  logic                    fast_avg_select;
  hfc_pkg::hfc_src_t       hold_source;
  hfc_pkg::hfc_src_t       brief_source;
  hfc_pkg::hfc_src_t       exp_hold;
  hfc_pkg::hfc_src_t       exp_brief;
  logic [7:0]              pol;
  int                      fail_count;
  int                      cmp_count;

  // Device under test
  hfc_regs dut_u (
    .clock               (clock),
    .resetn              (resetn),
    .cs                  (cs),
    .wr_strobe           (wr_strobe),
    .rd_strobe           (rd_strobe),
    .addr                (addr),
    .wdata               (wdata),
    .manual_holdover_sel (manual_holdover_sel),
    .fast_avg            (fast_avg),
    .slow_avg            (slow_avg),
    .rdata               (rdata),
    .hold_offset_word    (hold_offset_word),
    .fast_avg_select     (fast_avg_select),
    .hold_source         (hold_source),
    .brief_source        (brief_source)
  );

  // 40 MHz clock
  always #12.5 clock = ~clock;

  // ==========================================================
  // Access tasks
  task automatic chk(input logic [18:0] got, input logic [18:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One write cycle, taken at the rising edge in between
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clock);
    cs        = 1'b1;
    wr_strobe = 1'b1;
    addr      = a;
    wdata     = d;
    @(negedge clock);
    cs        = 1'b0;
    wr_strobe = 1'b0;
  endtask

  // One read cycle, masked compare of the returned byte
  task automatic rd(input logic [6:0] a, input logic [7:0] e, input logic [7:0] m);
    @(negedge clock);
    cs        = 1'b1;
    rd_strobe = 1'b1;
    addr      = a;
    @(negedge clock);
    cs        = 1'b0;
    rd_strobe = 1'b0;
    chk({11'h000, rdata & m}, {11'h000, e & m});
  endtask

  // Verdict and end of run
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    clock = 1'b0;
    resetn = 1'b0;
    cs = 1'b0;
    wr_strobe = 1'b0;
    rd_strobe = 1'b0;
    addr = 7'h00;
    wdata = 8'h00;
    manual_holdover_sel = 1'b0;
    fast_avg = 19'h4C3B2;
    slow_avg = 19'h2A1F0;
    fail_count = 0;
    cmp_count = 0;
    repeat (2) @(negedge clock);
    resetn = 1'b1;
    @(negedge clock);
    chk(hold_offset_word, 19'h00000);
    chk({18'h00000, fast_avg_select}, 19'h00000);
    chk({15'h0000, hold_source}, {15'h0000, hfc_pkg::HFC_SRC_SLOW});
    chk({15'h0000, brief_source}, {15'h0000, hfc_pkg::HFC_SRC_FROZEN});
    rd(hfc_pkg::HFC_ADDR_OFFSET_LOW, 8'h00, 8'hFF);
    rd(hfc_pkg::HFC_ADDR_OFFSET_MID, 8'h00, 8'hFF);
    rd(hfc_pkg::HFC_ADDR_POLICY, 8'h88, 8'hFF);
    // Software copy of a filtered live loop offset, negative value
    wr(hfc_pkg::HFC_ADDR_OFFSET_LOW, 8'hA5);
    wr(hfc_pkg::HFC_ADDR_OFFSET_MID, 8'h5A);
    wr(hfc_pkg::HFC_ADDR_POLICY, 8'h8F);
    chk(hold_offset_word, 19'h75AA5);
    chk({18'h00000, hold_offset_word < 0}, 19'h00001);
    rd(hfc_pkg::HFC_ADDR_OFFSET_LOW, 8'hA5, 8'hFF);
    rd(hfc_pkg::HFC_ADDR_OFFSET_MID, 8'h5A, 8'hFF);
    rd(hfc_pkg::HFC_ADDR_POLICY, 8'h8F, 8'hFF);
    // Unmapped place: write ignored, read gives zero
    wr(7'h41, 8'h3C);
    rd(7'h41, 8'h00, 8'hFF);
    rd(hfc_pkg::HFC_ADDR_OFFSET_LOW, 8'hA5, 8'hFF);
    // Averaged read-back, slow then fast
    wr(hfc_pkg::HFC_ADDR_POLICY, 8'h2F);
    rd(hfc_pkg::HFC_ADDR_OFFSET_LOW, 8'hF0, 8'hFF);
    rd(hfc_pkg::HFC_ADDR_OFFSET_MID, 8'hA1, 8'hFF);
    rd(hfc_pkg::HFC_ADDR_POLICY, 8'h2A, 8'hFF);
    wr(hfc_pkg::HFC_ADDR_POLICY, 8'h6F);
    rd(hfc_pkg::HFC_ADDR_OFFSET_LOW, 8'hB2, 8'hFF);
    rd(hfc_pkg::HFC_ADDR_OFFSET_MID, 8'hC3, 8'hFF);
    rd(hfc_pkg::HFC_ADDR_POLICY, 8'h6C, 8'hFF);
    chk(hold_offset_word, 19'h75AA5);
    // Every combination of policy bits 7:3 (bits 2:0 held at 7) with and without manual mode
    for (int k = 0; k < 64; k++) begin
      pol = {k[4:0], 3'h7};
      manual_holdover_sel = k[5];
      wr(hfc_pkg::HFC_ADDR_POLICY, pol);
      @(negedge clock);
      exp_hold = k[5] ? hfc_pkg::HFC_SRC_MANUAL : !pol[7] ? hfc_pkg::HFC_SRC_FROZEN :
                 pol[6] ? hfc_pkg::HFC_SRC_FAST : hfc_pkg::HFC_SRC_SLOW;
      case (pol[4:3])
        2'h0:    exp_brief = exp_hold;
        2'h1:    exp_brief = hfc_pkg::HFC_SRC_FROZEN;
        2'h2:    exp_brief = hfc_pkg::HFC_SRC_FAST;
        default: exp_brief = hfc_pkg::HFC_SRC_SLOW;
      endcase
      chk({18'h00000, fast_avg_select}, {18'h00000, pol[6]});
      chk({15'h0000, hold_source}, {15'h0000, exp_hold});
      chk({15'h0000, brief_source}, {15'h0000, exp_brief});
    end
    // Second reset in mid-run, manual mode released at the same edge as reset is asserted
    @(negedge clock);
    manual_holdover_sel = 1'b0;
    resetn = 1'b0;
    @(negedge clock);
    resetn = 1'b1;
    chk(hold_offset_word, 19'h00000);
    rd(hfc_pkg::HFC_ADDR_POLICY, 8'h88, 8'hFF);
    rd(hfc_pkg::HFC_ADDR_OFFSET_MID, 8'h00, 8'hFF);
    chk({18'h00000, fast_avg_select}, 19'h00000);
    chk({15'h0000, hold_source}, {15'h0000, hfc_pkg::HFC_SRC_SLOW});
    chk({15'h0000, brief_source}, {15'h0000, hfc_pkg::HFC_SRC_FROZEN});
    conclude();
  end
endmodule
